// [hdl/hsra_top.sv]
// Host serial register access port: strap select, UART, SPI and I2C slaves.
`timescale 1ns/10ps

// Write buffer with valid and ready on both sides.
module hsra_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Depth must be a power of two; pointers carry one wrap bit.
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } hsra_fifo_st_t;

  hsra_fifo_st_t s;
  hsra_fifo_st_t next_s;
  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit.
  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign empty = (s.wp == s.rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s.mem[s.rp[AW-1:0]];

  // Pointer and storage update.
  always_comb begin
    next_s = s;
    if (in_valid && !full) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// How it works
// - SPI first byte bit 7: read one, write zero.
// - SPI bits six to one address; bit zero zero.
// - UART starts at 9.6 kBd after reset.
// - Rate register: 3-bit exponent, 5-bit mantissa.
// - Bit period from crystal, mantissa, exponent formula.
// - UART character: start zero, eight data, stop one.
// - UART bytes travel least significant bit first.
// - UART read: address in, one data byte out.
// - UART write: address, data; address echoed back.
// - UART address: bit 7 direction, 5..0 register.
// - Line enable clear switches request and aux off.
// - I2C slave only: never drives clock.
// - I2C works at standard, fast, high-speed rates.
// - SDA driven low or released only.
// - Glitch filter on both I2C lines when selected.
// - SDA changes only while SCL low.
// - START and STOP detected while SCL high.
// - Bus busy from START until STOP.
// - Repeated START restarts address reception.
// - I2C bytes MSB first, then acknowledge slot.
// - Any number of bytes per I2C frame.
// - Straps select the host port after reset.
// - SPI samples on SCK rise, shifts on fall.
module hsra_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Shared host pins, inputs.
  input wire logic pin_i2c_sel,
  input wire logic pin_ea,
  input wire logic pin_sda_in,
  input wire logic pin_d7_in,
  input wire logic pin_d6_in,
  input wire logic pin_d5_in,
  input wire logic [3:0] pin_d4_1_in,
  // Shared host pins, output levels and enables.
  output hsra_pkg::hsra_pin_t pin_out,
  output hsra_pkg::hsra_pin_t pin_oe,
  // Register write stream to the core.
  input wire logic drain_hold,
  output logic wr_valid,
  output hsra_pkg::hsra_wr_t wr_apply,
  // Configuration and status.
  input wire logic overflow_clear,
  output logic write_overflow,
  output hsra_pkg::hsra_if_t host_if,
  output logic [2:0] rate_exponent,
  output logic [4:0] rate_mantissa,
  output logic serial_line_enable
);

  // Whole state of the port.
  typedef struct packed {
    logic [9:0] sy1;
    logic [9:0] sy2;
    logic [1:0] strap_cnt;
    logic started;
    hsra_pkg::hsra_if_t mode;
    logic [6:0] i2c_addr;
    logic [63:0][7:0] regs;
    logic [hsra_pkg::SPIKE_CYC-1:0] hist_scl;
    logic [hsra_pkg::SPIKE_CYC-1:0] hist_sda;
    logic fscl;
    logic fsda;
    logic [17:0] acc;
    hsra_pkg::hsra_rx_t rx_state;
    logic [12:0] rx_tick;
    logic [2:0] rx_bits;
    logic [7:0] rx_sh;
    logic u_have_addr;
    logic [5:0] u_addr;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [12:0] tx_tick;
    logic sp_first;
    logic sp_read;
    logic [5:0] sp_addr;
    logic [2:0] sp_cnt;
    logic [7:0] sp_sh;
    logic [7:0] sp_tx;
    logic sp_miso;
    logic sp_miso_sck;
    hsra_pkg::hsra_i2_t i2_state;
    logic [2:0] i2_cnt;
    logic [7:0] i2_sh;
    logic i2_read;
    logic i2_have_reg;
    logic [5:0] i2_reg;
    logic [7:0] i2_tx;
    logic i2_low;
    logic prev_scl;
    logic prev_sda;
    logic push;
    hsra_pkg::hsra_wr_t push_data;
    logic wr_valid;
    hsra_pkg::hsra_wr_t wr;
    logic ovf;
    hsra_pkg::hsra_pin_t pout;
    hsra_pkg::hsra_pin_t poe;
  } hsra_st_t;

  hsra_st_t s;
  hsra_st_t next_s;
  logic fifo_in_ready;
  logic fifo_out_valid;
  hsra_pkg::hsra_wr_t fifo_out_data;

  // Bit period in crystal ticks from the rate register.
  function automatic logic [12:0] bit_ticks(input logic [7:0] r);
    logic [2:0] e;
    logic [12:0] base;
    e = r[hsra_pkg::EXP_MSB:hsra_pkg::EXP_LSB];
    base = {8'h00, r[hsra_pkg::MANT_MSB:0]};
    if (e == 3'h0) begin
      bit_ticks = base + 13'h0001;
    end else begin
      bit_ticks = (base + hsra_pkg::RATE_OFFSET) << (e - 3'h1);
    end
  endfunction

  // Writes queue here so that a stalled core never blocks the serial side.
  hsra_fifo #(
    .WIDTH($bits(hsra_pkg::hsra_wr_t)),
    .DEPTH(hsra_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(s.push),
    .in_ready(fifo_in_ready),
    .in_data(s.push_data),
    .out_valid(fifo_out_valid),
    .out_ready(!drain_hold),
    .out_data(fifo_out_data)
  );

  // All next-state logic of the three host ports.
  always_comb begin
    logic [7:0] rate;
    logic [12:0] period;
    logic [12:0] half;
    logic [12:0] target;
    logic xt;
    logic urx;
    logic nss;
    logic sck;
    logic rx_due;
    logic tx_due;
    logic byte_ok;
    logic [7:0] b;
    logic scl_rise;
    logic scl_fall;
    logic i2_start;
    logic i2_stop;
    logic [17:0] acc_sum;
    next_s = s;
    next_s.push = 1'b0;
    next_s.wr_valid = 1'b0;
    byte_ok = 1'b0;
    b = 8'h00;
    // Two flip-flop synchronisers; only sy2 is read below.
    next_s.sy1 = {pin_i2c_sel, pin_ea, pin_sda_in, pin_d7_in, pin_d6_in,
                  pin_d5_in, pin_d4_1_in};
    next_s.sy2 = s.sy1;
    // Straps are caught a few cycles after release, once sy2 holds them.
    if (!s.started) begin
      if (s.strap_cnt == hsra_pkg::STRAP_WAIT) begin
        next_s.started = 1'b1;
        if (s.sy2[hsra_pkg::SY_I2C]) begin
          next_s.mode = hsra_pkg::HSRA_IF_I2C;
        end else if (s.sy2[hsra_pkg::SY_EA]) begin
          next_s.mode = hsra_pkg::HSRA_IF_SPI;
        end else begin
          next_s.mode = hsra_pkg::HSRA_IF_UART;
        end
        // Address pins: D6 is bit 0, D5 bit 1, D4 bit 2; D3..D1 bits 3..5 only with EA high.
        if (s.sy2[hsra_pkg::SY_EA]) begin
          next_s.i2c_addr = {1'b0, s.sy2[0], s.sy2[1], s.sy2[2], s.sy2[3],
                             s.sy2[hsra_pkg::SY_D5], s.sy2[hsra_pkg::SY_D6]};
        end else begin
          next_s.i2c_addr = {hsra_pkg::I2C_ADDR_HI, s.sy2[3],
                             s.sy2[hsra_pkg::SY_D5], s.sy2[hsra_pkg::SY_D6]};
        end
      end else begin
        next_s.strap_cnt = s.strap_cnt + 2'h1;
      end
    end
    // Spike filter: a level is taken only after it held for a while.
    next_s.hist_scl = {s.hist_scl[hsra_pkg::SPIKE_CYC-2:0],
                       s.sy2[hsra_pkg::SY_D7]};
    next_s.hist_sda = {s.hist_sda[hsra_pkg::SPIKE_CYC-2:0],
                       s.sy2[hsra_pkg::SY_SDA]};
    if (s.mode != hsra_pkg::HSRA_IF_I2C) begin
      next_s.fscl = s.sy2[hsra_pkg::SY_D7];
      next_s.fsda = s.sy2[hsra_pkg::SY_SDA];
    end else begin
      if (&{s.hist_scl, s.sy2[hsra_pkg::SY_D7]}) next_s.fscl = 1'b1;
      if (~|{s.hist_scl, s.sy2[hsra_pkg::SY_D7]}) next_s.fscl = 1'b0;
      if (&{s.hist_sda, s.sy2[hsra_pkg::SY_SDA]}) next_s.fsda = 1'b1;
      if (~|{s.hist_sda, s.sy2[hsra_pkg::SY_SDA]}) next_s.fsda = 1'b0;
    end
    // Crystal tick enable from a phase accumulator at 27.12/200.
    acc_sum = s.acc + hsra_pkg::ACC_STEP;
    xt = (acc_sum >= hsra_pkg::ACC_WRAP);
    next_s.acc = xt ? acc_sum - hsra_pkg::ACC_WRAP : acc_sum;
    // Bit timing follows the live rate register; reset value is 9.6 kBd.
    rate = s.regs[hsra_pkg::RATE_ADDR];
    period = bit_ticks(rate);
    half = (period >> 1) == 13'h0000 ? 13'h0001 : (period >> 1);
    // ---- Asynchronous receiver on the SDA pin. ----
    urx = s.fsda;
    target = (s.rx_state == hsra_pkg::RX_START) ? half : period;
    rx_due = xt && ((s.rx_tick + 13'h0001) >= target);
    if (xt) begin
      next_s.rx_tick = rx_due ? 13'h0000 : s.rx_tick + 13'h0001;
    end
    case (s.rx_state)
      hsra_pkg::RX_IDLE: begin
        if (!urx && s.mode == hsra_pkg::HSRA_IF_UART && s.started) begin
          next_s.rx_state = hsra_pkg::RX_START;
          next_s.rx_tick = 13'h0000;
        end
      end
      hsra_pkg::RX_START: begin
        // A start that is high at its centre was a glitch.
        if (rx_due) begin
          next_s.rx_state = urx ? hsra_pkg::RX_IDLE : hsra_pkg::RX_DATA;
          next_s.rx_bits = 3'h0;
        end
      end
      hsra_pkg::RX_DATA: begin
        if (rx_due) begin
          next_s.rx_sh = {urx, s.rx_sh[7:1]};
          next_s.rx_bits = s.rx_bits + 3'h1;
          if (s.rx_bits == 3'h7) next_s.rx_state = hsra_pkg::RX_STOP;
        end
      end
      hsra_pkg::RX_STOP: begin
        if (rx_due) begin
          byte_ok = urx;
          next_s.rx_state = hsra_pkg::RX_IDLE;
        end
      end
      default: next_s.rx_state = hsra_pkg::RX_IDLE;
    endcase
    // ---- Asynchronous transmitter on D7. ----
    tx_due = xt && ((s.tx_tick + 13'h0001) >= period);
    if (s.tx_busy && xt) begin
      next_s.tx_tick = tx_due ? 13'h0000 : s.tx_tick + 13'h0001;
      if (tx_due) begin
        next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
        next_s.tx_cnt = s.tx_cnt - 4'h1;
        if (s.tx_cnt == 4'h1) next_s.tx_busy = 1'b0;
      end
    end
    // A good character is an address or the data of a pending write.
    if (byte_ok) begin
      if (!s.u_have_addr) begin
        if (s.rx_sh[hsra_pkg::RW_BIT]) begin
          b = s.regs[s.rx_sh[5:0]];
        end else begin
          next_s.u_have_addr = 1'b1;
          next_s.u_addr = s.rx_sh[5:0];
          b = s.rx_sh;
        end
        // A reply that finds the transmitter busy is dropped.
        if (!s.tx_busy) begin
          next_s.tx_busy = 1'b1;
          next_s.tx_sh = {1'b1, b, 1'b0};
          next_s.tx_cnt = 4'hA;
          next_s.tx_tick = 13'h0000;
        end
      end else begin
        next_s.u_have_addr = 1'b0;
        next_s.push = 1'b1;
        next_s.push_data = '{addr: s.u_addr, data: s.rx_sh};
      end
    end
    // ---- SPI slave: NSS on SDA, SCK on D5, MOSI on D6, MISO on D7. ----
    nss = s.sy2[hsra_pkg::SY_SDA];
    sck = s.sy2[hsra_pkg::SY_D5];
    if (nss || s.mode != hsra_pkg::HSRA_IF_SPI) begin
      next_s.sp_first = 1'b1;
      next_s.sp_cnt = 3'h0;
    end else if (sck && !s.sp_miso_sck) begin
      next_s.sp_sh = {s.sp_sh[6:0], s.sy2[hsra_pkg::SY_D6]};
      next_s.sp_cnt = s.sp_cnt + 3'h1;
      if (s.sp_cnt == 3'h7) begin
        b = {s.sp_sh[6:0], s.sy2[hsra_pkg::SY_D6]};
        if (s.sp_first) begin
          next_s.sp_first = 1'b0;
          next_s.sp_read = b[hsra_pkg::RW_BIT];
          next_s.sp_addr = b[6:1];
          next_s.sp_tx = s.regs[b[6:1]];
        end else if (s.sp_read) begin
          next_s.sp_tx = s.regs[b[6:1]];
        end else begin
          next_s.push = 1'b1;
          next_s.push_data = '{addr: s.sp_addr, data: b};
        end
      end
    end else if (!sck && s.sp_miso_sck) begin
      next_s.sp_miso = s.sp_tx[7];
      next_s.sp_tx = {s.sp_tx[6:0], 1'b0};
    end
    next_s.sp_miso_sck = sck;
    // ---- I2C slave: SDA on SDA, SCL on D7, filtered levels. ----
    scl_rise = s.fscl && !s.prev_scl;
    scl_fall = !s.fscl && s.prev_scl;
    i2_start = s.fscl && s.prev_scl && s.prev_sda && !s.fsda;
    i2_stop = s.fscl && s.prev_scl && !s.prev_sda && s.fsda;
    next_s.prev_scl = s.fscl;
    next_s.prev_sda = s.fsda;
    if (s.mode != hsra_pkg::HSRA_IF_I2C || !s.started) begin
      next_s.i2_state = hsra_pkg::I2_IDLE;
      next_s.i2_low = 1'b0;
    end else if (i2_start) begin
      // Repeated START is handled exactly like a first one.
      next_s.i2_state = hsra_pkg::I2_ADDR;
      next_s.i2_cnt = 3'h0;
      next_s.i2_low = 1'b0;
    end else if (i2_stop) begin
      next_s.i2_state = hsra_pkg::I2_IDLE;
      next_s.i2_low = 1'b0;
    end else if (scl_rise) begin
      // Bits are taken while SCL is high, MSB first.
      case (s.i2_state)
        hsra_pkg::I2_ADDR, hsra_pkg::I2_WR: begin
          b = {s.i2_sh[6:0], s.fsda};
          next_s.i2_sh = b;
          next_s.i2_cnt = s.i2_cnt + 3'h1;
          if (s.i2_cnt == 3'h7 && s.i2_state == hsra_pkg::I2_ADDR) begin
            next_s.i2_read = b[0];
            next_s.i2_state = (b[7:1] == s.i2c_addr) ?
                              hsra_pkg::I2_ADDR_ACKP : hsra_pkg::I2_SKIP;
          end else if (s.i2_cnt == 3'h7) begin
            next_s.i2_state = hsra_pkg::I2_WR_ACKP;
            next_s.i2_have_reg = 1'b1;
            if (s.i2_have_reg) begin
              next_s.push = 1'b1;
              next_s.push_data = '{addr: s.i2_reg, data: b};
            end else begin
              next_s.i2_reg = b[5:0];
            end
          end
        end
        hsra_pkg::I2_RD: begin
          next_s.i2_cnt = s.i2_cnt + 3'h1;
          if (s.i2_cnt == 3'h7) next_s.i2_state = hsra_pkg::I2_RD_REL;
        end
        hsra_pkg::I2_RD_ACK: begin
          // A missing acknowledge ends the read; wait for STOP or START.
          next_s.i2_state = s.fsda ? hsra_pkg::I2_SKIP : hsra_pkg::I2_RD_FIRST;
        end
        default: next_s.i2_state = s.i2_state;
      endcase
    end else if (scl_fall) begin
      // SDA only ever changes here, with SCL low.
      case (s.i2_state)
        hsra_pkg::I2_ADDR_ACKP, hsra_pkg::I2_WR_ACKP: begin
          next_s.i2_low = 1'b1;
          next_s.i2_state = (s.i2_state == hsra_pkg::I2_ADDR_ACKP) ?
                            hsra_pkg::I2_ADDR_ACK : hsra_pkg::I2_WR_ACK;
        end
        hsra_pkg::I2_ADDR_ACK, hsra_pkg::I2_RD_FIRST: begin
          next_s.i2_cnt = 3'h0;
          if (s.i2_state == hsra_pkg::I2_ADDR_ACK && !s.i2_read) begin
            next_s.i2_low = 1'b0;
            next_s.i2_state = hsra_pkg::I2_WR;
            next_s.i2_have_reg = 1'b0;
          end else begin
            b = s.regs[s.i2_reg];
            next_s.i2_low = !b[7];
            next_s.i2_tx = {b[6:0], 1'b0};
            next_s.i2_state = hsra_pkg::I2_RD;
          end
        end
        hsra_pkg::I2_WR_ACK: begin
          next_s.i2_low = 1'b0;
          next_s.i2_state = hsra_pkg::I2_WR;
          next_s.i2_cnt = 3'h0;
        end
        hsra_pkg::I2_RD: begin
          next_s.i2_low = !s.i2_tx[7];
          next_s.i2_tx = {s.i2_tx[6:0], 1'b0};
        end
        hsra_pkg::I2_RD_REL: begin
          next_s.i2_low = 1'b0;
          next_s.i2_state = hsra_pkg::I2_RD_ACK;
        end
        default: next_s.i2_state = s.i2_state;
      endcase
    end
    // ---- Buffer drain into the register array. ----
    // Reads see the array, so a write still queued is not yet visible.
    if (fifo_out_valid && !drain_hold) begin
      next_s.regs[fifo_out_data.addr] = fifo_out_data.data;
      next_s.wr_valid = 1'b1;
      next_s.wr = fifo_out_data;
    end
    // Overflow is sticky; a new drop wins over a clear in the same cycle.
    if (overflow_clear) next_s.ovf = 1'b0;
    if (s.push && !fifo_in_ready) next_s.ovf = 1'b1;
    // ---- Pin drivers, all registered. ----
    next_s.pout = '0;
    next_s.poe = '0;
    if (s.started) begin
      case (s.mode)
        hsra_pkg::HSRA_IF_UART: begin
          next_s.pout.d7 = s.tx_busy ? s.tx_sh[0] : 1'b1;
          next_s.poe.d7 = 1'b1;
          next_s.pout.d6 = urx;
          next_s.pout.d5 = !s.tx_busy;
          next_s.poe.d6 = s.regs[hsra_pkg::TPIN_ADDR][hsra_pkg::LINE_EN_BIT];
          next_s.poe.d5 = s.regs[hsra_pkg::TPIN_ADDR][hsra_pkg::LINE_EN_BIT];
        end
        hsra_pkg::HSRA_IF_SPI: begin
          next_s.pout.d7 = s.sp_miso;
          next_s.poe.d7 = !nss;
        end
        hsra_pkg::HSRA_IF_I2C: begin
          // SCL is never driven; SDA is pulled low or released.
          next_s.poe.sda = s.i2_low;
        end
        default: next_s.poe = '0;
      endcase
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.regs[hsra_pkg::RATE_ADDR] <= hsra_pkg::RATE_RST;
      s.regs[hsra_pkg::TPIN_ADDR] <= hsra_pkg::TPIN_RST;
      s.fscl <= 1'b1;
      s.fsda <= 1'b1;
      // Edge history starts at the idle level, so no false edge follows.
      s.prev_scl <= 1'b1;
      s.prev_sda <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign pin_out = s.pout;
  assign pin_oe = s.poe;
  assign wr_valid = s.wr_valid;
  assign wr_apply = s.wr;
  assign write_overflow = s.ovf;
  assign host_if = s.mode;
  assign rate_exponent = s.regs[hsra_pkg::RATE_ADDR][7:5];
  assign rate_mantissa = s.regs[hsra_pkg::RATE_ADDR][4:0];
  assign serial_line_enable =
    s.regs[hsra_pkg::TPIN_ADDR][hsra_pkg::LINE_EN_BIT];

endmodule

// [hdl/hsra_pkg.sv]
// Shared constants and types of the host serial register access port.
package hsra_pkg;

  // Core clock period and the crystal rate the serial bit rate is built on.
  localparam int CLK_PERIOD_NS = 5;
  localparam int CORE_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int XTAL_KHZ = 27120;
  localparam logic [17:0] ACC_STEP = 18'(XTAL_KHZ);
  localparam logic [17:0] ACC_WRAP = 18'(CORE_KHZ);

  // Spike suppression on the two-wire lines, a longest time rounded down.
  localparam int I2C_SPIKE_NS = 10;
  localparam int SPIKE_CYC_RAW = I2C_SPIKE_NS / CLK_PERIOD_NS;
  localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;

  // Cycles after reset release before the strap levels are captured.
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Register map held inside the block.
  localparam logic [5:0] RATE_ADDR = 6'h1F;
  localparam logic [5:0] TPIN_ADDR = 6'h33;
  localparam logic [7:0] RATE_RST = 8'hEB;
  localparam logic [7:0] TPIN_RST = 8'h80;
  localparam int LINE_EN_BIT = 7;
  localparam int EXP_MSB = 7;
  localparam int EXP_LSB = 5;
  localparam int MANT_MSB = 4;
  localparam logic [12:0] RATE_OFFSET = 13'h0021;

  // Address byte layout on the serial ports.
  localparam int RW_BIT = 7;
  localparam logic [3:0] I2C_ADDR_HI = 4'h5;

  // Write buffer depth.
  localparam int FIFO_DEPTH = 32;

  // Positions inside the synchronised pin vector.
  localparam int SY_I2C = 9;
  localparam int SY_EA = 8;
  localparam int SY_SDA = 7;
  localparam int SY_D7 = 6;
  localparam int SY_D6 = 5;
  localparam int SY_D5 = 4;

  // Host interface chosen by the straps.
  typedef enum logic [1:0] {
    HSRA_IF_UART = 2'b00,
    HSRA_IF_SPI = 2'b01,
    HSRA_IF_I2C = 2'b10
  } hsra_if_t;

  // Asynchronous receiver states.
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } hsra_rx_t;

  // Two-wire slave states.
  typedef enum logic [3:0] {
    I2_IDLE = 4'b0000,
    I2_ADDR = 4'b0001,
    I2_ADDR_ACKP = 4'b0010,
    I2_ADDR_ACK = 4'b0011,
    I2_WR = 4'b0100,
    I2_WR_ACKP = 4'b0101,
    I2_WR_ACK = 4'b0110,
    I2_RD_FIRST = 4'b0111,
    I2_RD = 4'b1000,
    I2_RD_REL = 4'b1001,
    I2_RD_ACK = 4'b1010,
    I2_SKIP = 4'b1011
  } hsra_i2_t;

  // One register write: address and data.
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } hsra_wr_t;

  // The four shared pins that the block can drive.
  typedef struct packed {
    logic sda;
    logic d7;
    logic d6;
    logic d5;
  } hsra_pin_t;

endpackage

// [testbench/hsra_properties.sv]
// Timing checks on the host serial port's pins and register images.
`timescale 1ns/10ps
module hsra_properties (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Watched pins and outputs.
  input wire logic pin_sda_in,
  input hsra_pkg::hsra_pin_t pin_out,
  input hsra_pkg::hsra_pin_t pin_oe,
  input wire logic wr_valid,
  input hsra_pkg::hsra_wr_t wr_apply,
  input hsra_pkg::hsra_if_t host_if,
  input wire logic [2:0] rate_exponent,
  input wire logic [4:0] rate_mantissa,
  input wire logic serial_line_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Latest write data, so a register image can be tied to its cause.
  logic [7:0] last_wr;
  always_ff @(posedge core_clk)
    if (wr_valid)
      last_wr <= wr_apply.data;
  a_rate_reset: assert property ($rose(reset_n) |->
    {rate_exponent, rate_mantissa} == 8'hEB) else $error("rate reset");
  a_rate_write: assert property (wr_valid &&
    wr_apply.addr == hsra_pkg::RATE_ADDR |->
    ##[1:2] {rate_exponent, rate_mantissa} == last_wr) else $error("rate");
  a_line_write: assert property (wr_valid &&
    wr_apply.addr == hsra_pkg::TPIN_ADDR |->
    ##[1:2] serial_line_enable == last_wr[7]) else $error("line bit");
  a_line_off: assert property (!serial_line_enable [*2] |->
    !pin_oe.d6 && !pin_oe.d5) else $error("aux lines on");
  a_scl_never: assert property (host_if == hsra_pkg::HSRA_IF_I2C |->
    !pin_oe.d7) else $error("clock driven");
  a_sda_low: assert property (pin_oe.sda |-> !pin_out.sda)
    else $error("data driven high");
  a_miso_on: assert property ((host_if == hsra_pkg::HSRA_IF_SPI &&
    !pin_sda_in) [*6] |-> pin_oe.d7) else $error("output off");
  a_if_kept: assert property ($changed(host_if) |->
    !$past(reset_n, 8)) else $error("port changed");
endmodule
bind hsra_top hsra_properties i_props (.core_clk(core_clk),
  .reset_n(reset_n), .pin_sda_in(pin_sda_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .wr_valid(wr_valid), .wr_apply(wr_apply),
  .host_if(host_if), .rate_exponent(rate_exponent),
  .rate_mantissa(rate_mantissa), .serial_line_enable(serial_line_enable));

// [testbench/hsra_spi_host.sv]
// Host microcontroller model: SPI and two-wire master on the shared pins.
`timescale 1ns/10ps
module hsra_spi_host (
  // Core clock that paces the link.
  input wire logic core_clk,
  // Link lines; idle is deselected with the clock low.
  output logic nss_n = 1'b1,
  output logic sck = 1'b0,
  output logic mosi = 1'b0,
  input wire logic miso,
  // Byte taken from the device and its one-cycle strobe.
  output logic [7:0] got = 8'h00,
  output logic got_stb = 1'b0
);
  // Half of the 160 ns link period, well above the block's minimum.
  task automatic half();
    repeat (16) @(posedge core_clk);
  endtask
  task automatic open();
    nss_n <= 1'b0;
    half();
  endtask
  // One byte each way, most significant bit first.
  task automatic xfer(input logic [7:0] tx, input logic report);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      half();
      sck <= 1'b1;
      got[i] <= miso;
      half();
      sck <= 1'b0;
    end
    got_stb <= report;
    @(posedge core_clk);
    got_stb <= 1'b0;
  endtask
  // Deselect; the released data line does not keep its last bit.
  task automatic close();
    half();
    nss_n <= 1'b1;
    mosi <= ~mosi;
    half();
  endtask
  // Two-wire write: SCL on sck, SDA on nss_n; the last bit ends in STOP.
  task automatic i2c_wr(input logic [27:0] bits);
    sck <= 1'b1;
    half();
    nss_n <= 1'b0;
    for (int i = 27; i >= 0; i--) begin
      half();
      sck <= 1'b0;
      half();
      nss_n <= bits[i];
      half();
      sck <= 1'b1;
    end
    half();
    nss_n <= 1'b1;
    half();
    sck <= 1'b0;
  endtask
endmodule

// [testbench/testbench.sv]
// Bench: strap choice, SPI register traffic and write buffer overflow.
`timescale 1ns/10ps
module testbench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic i2c_sel = 1'b0;
  logic ea = 1'b0;
  logic drain_hold = 1'b0;
  logic overflow_clear = 1'b0;
  logic nss_n, sck, mosi, got_stb, wr_valid, write_overflow, line_en;
  logic [7:0] got, keep;
  logic [2:0] rate_exp;
  logic [4:0] rate_mant;
  hsra_pkg::hsra_pin_t pin_out, pin_oe;
  hsra_pkg::hsra_wr_t wr_apply;
  hsra_pkg::hsra_if_t host_if;
  logic [15:0] expq[$];
  int bad_count = 0;
  int checked = 0;
  int seed = 52;
  // The data line is pulled up; the block may only pull it low.
  wire sda_line = nss_n & ~(pin_oe.sda & ~pin_out.sda);
  wire scl_line = pin_oe.d7 ? pin_out.d7 : sck;
  wire [15:0] image = {5'h00, host_if, rate_exp, rate_mant, line_en};
  initial forever #2.5 core_clk = ~core_clk;
  hsra_spi_host i_host (.core_clk(core_clk), .nss_n(nss_n), .sck(sck),
    .mosi(mosi), .miso(pin_out.d7), .got(got), .got_stb(got_stb));
  hsra_top i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .pin_i2c_sel(i2c_sel), .pin_ea(ea), .pin_sda_in(sda_line),
    .pin_d7_in(scl_line), .pin_d6_in(mosi), .pin_d5_in(sck),
    .pin_d4_1_in(4'h0), .pin_out(pin_out), .pin_oe(pin_oe),
    .drain_hold(drain_hold), .wr_valid(wr_valid), .wr_apply(wr_apply),
    .overflow_clear(overflow_clear), .write_overflow(write_overflow),
    .host_if(host_if), .rate_exponent(rate_exp),
    .rate_mantissa(rate_mant), .serial_line_enable(line_en));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %h vs %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Straps are held across the release, as the capture needs them stable.
  task automatic restart(input logic sel, input logic e);
    @(posedge core_clk);
    reset_n <= 1'b0;
    i2c_sel <= sel;
    ea <= e;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask
  // Only what fits in the buffer is expected to come out.
  task automatic spi_wr(input logic [5:0] a, input logic [7:0] d, int n);
    logic [7:0] v;
    i_host.open();
    i_host.xfer({1'b0, a, 1'b0}, 1'b0);
    for (int k = 0; k < n; k++) begin
      v = (k == 0) ? d : 8'($random(seed));
      if (k < hsra_pkg::FIFO_DEPTH) begin
        expq.push_back({2'b01, a, v});
        keep = v;
      end
      i_host.xfer(v, 1'b0);
    end
    i_host.close();
  endtask
  task automatic spi_rd(input logic [5:0] a, input logic [7:0] want);
    i_host.open();
    i_host.xfer({1'b1, a, 1'b0}, 1'b0);
    expq.push_back({8'h80, want});
    i_host.xfer(8'h00, 1'b1);
    i_host.close();
  endtask
  // Bounded wait for every noted result to appear.
  task automatic drain();
    for (int i = 0; i < 4000 && expq.size() != 0; i++)
      @(posedge core_clk);
    if (expq.size() != 0) begin
      bad_count++;
      close_out();
    end
    repeat (4) @(posedge core_clk);
  endtask
  // Each result is matched to the oldest note.
  always @(posedge core_clk)
    if (wr_valid === 1'b1 || got_stb === 1'b1)
      check(wr_valid ? {2'b01, wr_apply} : {8'h80, got},
        expq.size() != 0 ? expq.pop_front() : 16'hFFFF);
  initial begin
    restart(1'b0, 1'b0);
    check(image, {5'h00, hsra_pkg::HSRA_IF_UART, 8'hEB, 1'b1});
    check({8'h00, pin_out, pin_oe}, 16'h0077);
    restart(1'b1, 1'b0);
    check(image, {5'h00, hsra_pkg::HSRA_IF_I2C, 8'hEB, 1'b1});
    check({12'h000, pin_oe}, 16'h0000);
    expq.push_back({2'b01, 6'h05, 8'hAB});
    i_host.i2c_wr({8'h50, 1'b1, 8'h05, 1'b1, 8'hAB, 2'b10});
    drain();
    restart(1'b0, 1'b1);
    check(image, {5'h00, hsra_pkg::HSRA_IF_SPI, 8'hEB, 1'b1});
    spi_wr(hsra_pkg::RATE_ADDR, 8'h15, 1);
    drain();
    check(image, {5'h00, hsra_pkg::HSRA_IF_SPI, 8'h15, 1'b1});
    spi_wr(hsra_pkg::TPIN_ADDR, 8'h00, 1);
    drain();
    check(image, {5'h00, hsra_pkg::HSRA_IF_SPI, 8'h15, 1'b0});
    spi_rd(hsra_pkg::RATE_ADDR, 8'h15);
    drain();
    // Stall the drain so one byte past the depth has nowhere to go.
    drain_hold <= 1'b1;
    spi_wr(6'h05, 8'h3C, 33);
    check({15'h0000, write_overflow}, 16'h0001);
    drain_hold <= 1'b0;
    overflow_clear <= 1'b1;
    drain();
    overflow_clear <= 1'b0;
    check({15'h0000, write_overflow}, 16'h0000);
    spi_rd(6'h05, keep);
    drain();
    close_out();
  end
endmodule
